// ### drab_pkg.sv
// package for the debug RAM access buffers: register indices, windows,
// carrier structs, the sequencer states and shared decode functions.
// assumes nothing of its surroundings; every user names drab_pkg:: items.
package drab_pkg;
	// ----------------------------------------------------------------
	// register indices on the dma/cpu side
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_BUF_LOW = 3'h0;
	localparam logic [2:0] REG_BUF_HIGH = 3'h1;
	localparam logic [2:0] REG_SRC_LOW = 3'h2;
	localparam logic [2:0] REG_SRC_HIGH = 3'h3;
	localparam logic [2:0] REG_DST_LOW = 3'h4;
	localparam logic [2:0] REG_DST_HIGH = 3'h5;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;

	// ----------------------------------------------------------------
	// address windows (low 24 bits) and address shaping
	// ----------------------------------------------------------------
	localparam logic [23:0] RAM_FIRST = 24'hffc000;
	localparam logic [23:0] RAM_LAST = 24'hffe7ff;
	localparam logic [23:0] ROM_FIRST = 24'h000000;
	localparam logic [23:0] ROM_LAST = 24'h03ffff;
	localparam logic [7:0] TARGET_TOP = 8'hff;
	localparam logic [1:0] SETTLE_DONE = 2'h3;
	localparam logic [1:0] SETTLE_STEP = 2'h1;
	localparam logic [1:0] BE_LOW = 2'h1;
	localparam logic [1:0] BE_HIGH = 2'h2;

	// ----------------------------------------------------------------
	// carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic req;
		logic write;
		logic space;
		logic [23:0] addr;
		logic [31:0] data;
	} drab_tool_t;

	typedef struct packed {
		logic valid;
		logic fetch;
		logic [31:0] addr;
	} drab_bus_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_XFER,
		ST_READY,
		ST_LOCKED
	} drab_state_t;

	// ----------------------------------------------------------------
	// shared decode
	// ----------------------------------------------------------------
	function automatic logic drab_in_window(input logic [23:0] a,
		input logic [23:0] first, input logic [23:0] last);
		drab_in_window = (a >= first) && (a <= last);
	endfunction : drab_in_window

	// word match ignoring the two lowest address bits
	function automatic logic drab_word_match(input logic [23:0] a,
		input logic [23:0] b);
		drab_word_match = (a[23:2] == b[23:2]);
	endfunction : drab_word_match
endpackage : drab_pkg

// ### drab_port.sv
// debug RAM access port: tool command capture, dma buffers and address
// registers, address-match event trigger.
// assumes a dma controller served by the two request lines, and tool pins
// (including the debug link clock) asynchronous to clk.
//
// Notes on behaviour
// - two 16-bit buffers pass RAM data between dma and tool both ways.
// - each buffer is written as a word or as single bytes.
// - source address low/high are set by tool, read-only for dma.
// - destination address low/high are set by tool, read-only for dma.
// - during tool write, destination high shows the address the tool sent.
// - during tool read, destination high shows the low buffer contents.
// - a command sent during reset is never answered; tool resets again.
// - before dma init no RAM access completes; ready never returns.
// - reset clears the event trigger setting.
// - a RAM trigger also fires on a data read, not on fetches.
// - ROM match only in internal ROM, RAM only in RAM; low bits ignored.
// - event trigger output is active low for one clock per matching bus cycle.
// - ready follows write completion; next command after sync drops.
// - addresses outside internal RAM get ready at once, no transfer.
`timescale 1ns/1ns
module drab_port #(
	parameter logic [31:0] BUFFER_ADDR = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic debugLinkClock,
	input wire drab_pkg::drab_tool_t toolIn,
	output logic toolReady,
	output logic [31:0] toolRdData,
	output logic eventTrigger_n,
	output logic addressSetupRequest,
	output logic readWriteTransferRequest,
	input wire logic dmaSetupDone,
	input wire logic dmaXferDone,
	input wire logic [2:0] regAddr,
	input wire logic regRd,
	input wire logic regWr,
	input wire logic [1:0] regBe,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	input wire drab_pkg::drab_bus_t busIn
);
	// ----------------------------------------------------------------
	// pin synchronisers: three stages, value taken when 2nd and 3rd agree
	// ----------------------------------------------------------------
	logic [2:0] lclkS_r, lclkS_nxt;
	logic lclkF_r, lclkF_nxt;
	drab_pkg::drab_tool_t toolS1_r, toolS2_r, toolS3_r, toolF_r;
	drab_pkg::drab_tool_t toolS1_nxt, toolS2_nxt, toolS3_nxt, toolF_nxt;
	logic linkRise;

	// filtering on agreement rejects a single sampled glitch on the pins
	always_comb begin
		lclkS_nxt = {lclkS_r[1:0], debugLinkClock};
		lclkF_nxt = (lclkS_r[1] == lclkS_r[2]) ? lclkS_r[2] : lclkF_r;
		toolS1_nxt = toolIn;
		toolS2_nxt = toolS1_r;
		toolS3_nxt = toolS2_r;
		toolF_nxt = (toolS2_r == toolS3_r) ? toolS3_r : toolF_r;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lclkS_r <= 3'h0;
			lclkF_r <= 1'b0;
			toolS1_r <= '0;
			toolS2_r <= '0;
			toolS3_r <= '0;
			toolF_r <= '0;
		end else if (clkEn) begin
			lclkS_r <= lclkS_nxt;
			lclkF_r <= lclkF_nxt;
			toolS1_r <= toolS1_nxt;
			toolS2_r <= toolS2_nxt;
			toolS3_r <= toolS3_nxt;
			toolF_r <= toolF_nxt;
		end
	end

	// link edge from the filtered level only
	assign linkRise = lclkF_nxt & ~lclkF_r;

	// ----------------------------------------------------------------
	// command sequencer, buffers and address registers
	// ----------------------------------------------------------------
	drab_pkg::drab_state_t state_r, state_nxt;
	logic [15:0] bufLow_r, bufLow_nxt, bufHigh_r, bufHigh_nxt;
	logic [31:0] srcAddr_r, srcAddr_nxt, dstAddr_r, dstAddr_nxt;
	logic opWrite_r, opWrite_nxt;
	logic [31:0] rdData_r, rdData_nxt;
	logic [15:0] regRdata_r, regRdata_nxt;
	logic [1:0] settle_r, settle_nxt;
	logic seenLow_r, seenLow_nxt;
	logic trigEn_r, trigEn_nxt, trigRom_r, trigRom_nxt;
	logic [23:0] trigAddr_r, trigAddr_nxt;
	logic startCmd, cmdInRam;
	logic [31:0] target;

	assign startCmd = linkRise & toolF_nxt.req & seenLow_r;
	assign cmdInRam = drab_pkg::drab_in_window(toolF_nxt.addr,
		drab_pkg::RAM_FIRST, drab_pkg::RAM_LAST);
	assign target = {drab_pkg::TARGET_TOP, toolF_nxt.addr};

	// next state of the sequencer and everything it loads
	always_comb begin
		state_nxt = state_r;
		bufLow_nxt = bufLow_r;
		bufHigh_nxt = bufHigh_r;
		srcAddr_nxt = srcAddr_r;
		dstAddr_nxt = dstAddr_r;
		opWrite_nxt = opWrite_r;
		rdData_nxt = rdData_r;
		settle_nxt = settle_r;
		seenLow_nxt = seenLow_r;
		trigEn_nxt = trigEn_r;
		trigRom_nxt = trigRom_r;
		trigAddr_nxt = trigAddr_r;
		// a request already up when the pins settle was sent in reset
		if (settle_r != drab_pkg::SETTLE_DONE) begin
			settle_nxt = settle_r + drab_pkg::SETTLE_STEP;
		end else if (!seenLow_r) begin
			if (toolF_nxt.req) begin
				state_nxt = drab_pkg::ST_LOCKED;
			end else begin
				seenLow_nxt = 1'b1;
			end
		end
		// dma side byte-lane writes into the data buffers
		if (regWr && regAddr == drab_pkg::REG_BUF_LOW) begin
			if (regBe[0]) bufLow_nxt[7:0] = regWdata[7:0];
			if (regBe[1]) bufLow_nxt[15:8] = regWdata[15:8];
		end
		if (regWr && regAddr == drab_pkg::REG_BUF_HIGH) begin
			if (regBe[0]) bufHigh_nxt[7:0] = regWdata[7:0];
			if (regBe[1]) bufHigh_nxt[15:8] = regWdata[15:8];
		end
		case (state_r)
			drab_pkg::ST_IDLE: begin
				if (startCmd && toolF_nxt.space) begin
					// debug space command programs the trigger
					trigEn_nxt = 1'b1;
					trigRom_nxt = toolF_nxt.data[0];
					trigAddr_nxt = toolF_nxt.addr;
					state_nxt = drab_pkg::ST_READY;
				end else if (startCmd && !cmdInRam) begin
					state_nxt = drab_pkg::ST_READY;
				end else if (startCmd) begin
					opWrite_nxt = toolF_nxt.write;
					if (toolF_nxt.write) begin
						bufLow_nxt = toolF_nxt.data[15:0];
						bufHigh_nxt = toolF_nxt.data[31:16];
						srcAddr_nxt = BUFFER_ADDR;
						dstAddr_nxt = target;
					end else begin
						srcAddr_nxt = target;
						dstAddr_nxt = BUFFER_ADDR;
					end
					state_nxt = drab_pkg::ST_ADDR;
				end
			end
			drab_pkg::ST_ADDR: begin
				// without dma init no done arrives and the port hangs
				if (dmaSetupDone) state_nxt = drab_pkg::ST_XFER;
			end
			drab_pkg::ST_XFER: begin
				if (dmaXferDone) begin
					rdData_nxt = {bufHigh_r, bufLow_r};
					state_nxt = drab_pkg::ST_READY;
				end
			end
			drab_pkg::ST_READY: begin
				if (!toolF_r.req) state_nxt = drab_pkg::ST_IDLE;
			end
			drab_pkg::ST_LOCKED: state_nxt = drab_pkg::ST_LOCKED;
			default: state_nxt = drab_pkg::ST_IDLE;
		endcase
	end

	// registered read data; destination high doubles as a window
	always_comb begin
		regRdata_nxt = regRdata_r;
		if (regRd) begin
			case (regAddr)
				drab_pkg::REG_BUF_LOW: regRdata_nxt = bufLow_r;
				drab_pkg::REG_BUF_HIGH: regRdata_nxt = bufHigh_r;
				drab_pkg::REG_SRC_LOW: regRdata_nxt = srcAddr_r[15:0];
				drab_pkg::REG_SRC_HIGH: regRdata_nxt = srcAddr_r[31:16];
				drab_pkg::REG_DST_LOW: regRdata_nxt = dstAddr_r[15:0];
				drab_pkg::REG_DST_HIGH: begin
					if (opWrite_r) begin
						regRdata_nxt = dstAddr_r[31:16];
					end else begin
						regRdata_nxt = bufLow_r;
					end
				end
				default: regRdata_nxt = drab_pkg::UNMAPPED_WORD;
			endcase
		end
	end

	// address and trigger settings start cleared from every reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= drab_pkg::ST_IDLE;
			bufLow_r <= drab_pkg::RESET_WORD;
			bufHigh_r <= drab_pkg::RESET_WORD;
			srcAddr_r <= drab_pkg::RESET_ADDR;
			dstAddr_r <= drab_pkg::RESET_ADDR;
			opWrite_r <= 1'b0;
			rdData_r <= drab_pkg::RESET_ADDR;
			regRdata_r <= drab_pkg::RESET_WORD;
			settle_r <= 2'h0;
			seenLow_r <= 1'b0;
			trigEn_r <= 1'b0;
			trigRom_r <= 1'b0;
			trigAddr_r <= 24'h000000;
		end else if (clkEn) begin
			state_r <= state_nxt;
			bufLow_r <= bufLow_nxt;
			bufHigh_r <= bufHigh_nxt;
			srcAddr_r <= srcAddr_nxt;
			dstAddr_r <= dstAddr_nxt;
			opWrite_r <= opWrite_nxt;
			rdData_r <= rdData_nxt;
			regRdata_r <= regRdata_nxt;
			settle_r <= settle_nxt;
			seenLow_r <= seenLow_nxt;
			trigEn_r <= trigEn_nxt;
			trigRom_r <= trigRom_nxt;
			trigAddr_r <= trigAddr_nxt;
		end
	end

	// requests are levels held until the dma reports done
	assign addressSetupRequest = (state_r == drab_pkg::ST_ADDR);
	assign readWriteTransferRequest = (state_r == drab_pkg::ST_XFER);
	assign toolReady = (state_r == drab_pkg::ST_READY);
	assign toolRdData = rdData_r;
	assign regRdata = regRdata_r;

	// ----------------------------------------------------------------
	// event trigger
	// ----------------------------------------------------------------
	logic trigFire, busMatch;
	logic trigOut_r, trigOut_nxt;

	assign busMatch = busIn.valid && trigEn_r &&
		drab_pkg::drab_word_match(busIn.addr[23:0], trigAddr_r);

	// rom fetches match only in rom, any non-fetch access only in ram
	always_comb begin
		if (trigRom_r) begin
			trigFire = busMatch && busIn.fetch &&
				drab_pkg::drab_in_window(busIn.addr[23:0],
				drab_pkg::ROM_FIRST, drab_pkg::ROM_LAST);
		end else begin
			trigFire = busMatch && !busIn.fetch &&
				drab_pkg::drab_in_window(busIn.addr[23:0],
				drab_pkg::RAM_FIRST, drab_pkg::RAM_LAST);
		end
		trigOut_nxt = ~trigFire;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trigOut_r <= 1'b1;
		end else if (clkEn) begin
			trigOut_r <= trigOut_nxt;
		end
	end

	assign eventTrigger_n = trigOut_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence seqSetupDone;
		clkEn && state_r == drab_pkg::ST_ADDR && dmaSetupDone;
	endsequence
	sequence seqXferDone;
		clkEn && state_r == drab_pkg::ST_XFER && dmaXferDone;
	endsequence

	AST_TRIG_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn && trigFire |=> !eventTrigger_n)
		else $error("trigger did not go low after a match");
	AST_TRIG_CLEARED: assert property (@(posedge clk) disable iff (!reset_n)
		!eventTrigger_n |-> $past(trigEn_r))
		else $error("trigger fired without a programmed setting");
	AST_ROM_ONLY_FETCH: assert property (@(posedge clk) disable iff (!reset_n)
		trigRom_r && !busIn.fetch |-> !trigFire)
		else $error("rom trigger fired on a non-fetch access");
	AST_RAM_READ_FIRES: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn && busMatch && !trigRom_r && !busIn.fetch &&
		busIn.addr[23:0] >= drab_pkg::RAM_FIRST &&
		busIn.addr[23:0] <= drab_pkg::RAM_LAST |=> !eventTrigger_n)
		else $error("ram data access match did not fire");
	AST_OUTSIDE_READY: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn && state_r == drab_pkg::ST_IDLE && startCmd &&
		!toolF_nxt.space && !cmdInRam |=> toolReady && !addressSetupRequest)
		else $error("outside address not answered at once");
	AST_SETUP_THEN_XFER: assert property (@(posedge clk) disable iff (!reset_n)
		seqSetupDone |=> readWriteTransferRequest && !addressSetupRequest)
		else $error("transfer request did not follow setup");
	AST_READY_AFTER_TOP: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(toolReady) && $past(state_r) == drab_pkg::ST_XFER
		|-> $past(dmaXferDone))
		else $error("ready before dma finished");
	AST_XFER_READY: assert property (@(posedge clk) disable iff (!reset_n)
		seqXferDone |=> toolReady && toolRdData == $past({bufHigh_r, bufLow_r}))
		else $error("read data not handed on at ready");
	AST_LOCK_SILENT: assert property (@(posedge clk) disable iff (!reset_n)
		state_r == drab_pkg::ST_LOCKED |=> !toolReady [*4])
		else $error("locked port answered ready");
	AST_DST_HIGH_READ: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn && regRd && regAddr == drab_pkg::REG_DST_HIGH && !opWrite_r
		|=> regRdata == $past(bufLow_r))
		else $error("destination high did not show low buffer");
	AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn && regWr && regAddr == drab_pkg::REG_BUF_LOW &&
		regBe == drab_pkg::BE_LOW && !startCmd
		|=> bufLow_r[15:8] == $past(bufLow_r[15:8]) &&
		bufLow_r[7:0] == $past(regWdata[7:0]))
		else $error("byte write touched the wrong lane");
endmodule : drab_port

// ### drab_tool_model.sv
// debug tool stand-in: one command frame at a time on the tool pins.
// assumes the bench calls its tasks from one process and watches ready.
`timescale 1ns/1ns
module drab_tool_model (
	input wire logic clk,
	input wire logic toolReady,
	output logic debugLinkClock,
	output drab_pkg::drab_tool_t toolIn
);
	// ----------------------------------------------------------------
	// idle pins
	// ----------------------------------------------------------------
	initial begin
		debugLinkClock = 1'b0;
		toolIn = '0;
	end

	// raise request alone, used to send during reset on purpose
	task automatic hold_req(input logic v);
		@(posedge clk);
		toolIn.req <= v;
	endtask : hold_req

	// one frame; link clock runs only inside it, 160 ns period
	task automatic send(input logic wr, input logic sp,
		input logic [23:0] a, input logic [31:0] d, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clk);
		toolIn <= '{req: 1'b1, write: wr, space: sp, addr: a, data: d};
		for (n = 0; n < 400 && !ok; n++) begin
			repeat (8) @(posedge clk);
			debugLinkClock <= ~debugLinkClock;
			ok = toolReady;
		end
		// released lines show the inverse, not the stale value
		debugLinkClock <= 1'b0;
		toolIn <= '{req: 1'b0, write: ~wr, space: ~sp, addr: ~a, data: ~d};
		// next frame only once ready has gone inactive
		for (n = 0; n < 40 && toolReady !== 1'b0; n++) begin
			@(posedge clk);
		end
		ok = ok & (toolReady === 1'b0);
	endtask : send
endmodule : drab_tool_model

// ### tb_drab_port.sv
// bench for the debug RAM access port: acts as dma and cpu bus.
// assumes drab_pkg and the tool stand-in are compiled first.
`timescale 1ns/1ns
module tb_drab_port;
	localparam logic [31:0] BUF_ADDR = 32'h0000_0100;
	logic clk, reset_n, clkEn, debugLinkClock, toolReady, eventTrigger_n;
	logic addressSetupRequest, readWriteTransferRequest;
	logic dmaSetupDone, dmaXferDone, regRd, regWr, dmaOn, expWr, ok;
	logic [31:0] toolRdData, expData, ramData;
	logic [23:0] expAddr;
	logic [2:0] regAddr;
	logic [1:0] regBe;
	logic [15:0] regWdata, regRdata, w;
	drab_pkg::drab_tool_t toolIn;
	drab_pkg::drab_bus_t busIn;
	int mismatches, cmpCount, setupCount, trigCount, t, i;

	drab_port #(.BUFFER_ADDR(BUF_ADDR)) dut (.clk(clk), .reset_n(reset_n),
		.clkEn(clkEn), .debugLinkClock(debugLinkClock), .toolIn(toolIn),
		.toolReady(toolReady), .toolRdData(toolRdData),
		.eventTrigger_n(eventTrigger_n),
		.addressSetupRequest(addressSetupRequest),
		.readWriteTransferRequest(readWriteTransferRequest),
		.dmaSetupDone(dmaSetupDone), .dmaXferDone(dmaXferDone),
		.regAddr(regAddr), .regRd(regRd), .regWr(regWr), .regBe(regBe),
		.regWdata(regWdata), .regRdata(regRdata), .busIn(busIn));
	drab_tool_model tool (.clk(clk), .toolReady(toolReady),
		.debugLinkClock(debugLinkClock), .toolIn(toolIn));

	// ----------------------------------------------------------------
	// clock, trigger pulse counter, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// counts low cycles, so a wide pulse shows as a count above one
	always @(posedge clk) begin
		if (eventTrigger_n === 1'b0) trigCount <= trigCount + 1;
	end
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (mismatches == 0 && cmpCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : do_reset

	// data is taken two edges after the strobe, once it has landed
	task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdata;
	endtask : reg_rd

	task automatic reg_wr(input logic [2:0] a, input logic [1:0] be,
		input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regBe <= be;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : reg_wr

	task automatic bus_hit(input logic [31:0] a, input logic f, input int n);
		t = trigCount;
		@(posedge clk);
		busIn <= '{valid: 1'b1, fetch: f, addr: a};
		@(posedge clk);
		busIn.valid <= 1'b0;
		repeat (3) @(posedge clk);
		check("trigger pulses", trigCount - t, n);
	endtask : bus_hit

	// dma side: both channels, checking what the port hands over
	task automatic dma_serve();
		logic [15:0] r [6];
		logic [31:0] tgt;
		int k;
		tgt = {drab_pkg::TARGET_TOP, expAddr};
		setupCount++;
		for (k = 2; k < 6; k++) begin
			reg_rd(3'(k), r[k]);
		end
		check("rw req early", {31'h0, readWriteTransferRequest}, 32'h0);
		check("src addr", {r[3], r[2]}, expWr ? BUF_ADDR : tgt);
		if (expWr) begin
			check("dst addr", {r[5], r[4]}, tgt);
		end else begin
			check("dst low", {16'h0, r[4]}, {16'h0, BUF_ADDR[15:0]});
		end
		dmaSetupDone <= 1'b1;
		@(posedge clk);
		dmaSetupDone <= 1'b0;
		for (k = 0; k < 8 && readWriteTransferRequest !== 1'b1; k++) begin
			@(posedge clk);
		end
		check("rw req", {31'h0, readWriteTransferRequest}, 32'h1);
		if (expWr) begin
			reg_rd(drab_pkg::REG_BUF_LOW, r[0]);
			reg_rd(drab_pkg::REG_BUF_HIGH, r[1]);
			check("write data", {r[1], r[0]}, expData);
			busIn <= '{valid: 1'b1, fetch: 1'b0, addr: tgt};
			@(posedge clk);
			busIn.valid <= 1'b0;
		end else begin
			reg_wr(drab_pkg::REG_BUF_LOW, 2'h3, ramData[15:0]);
			reg_wr(drab_pkg::REG_BUF_HIGH, 2'h3, ramData[31:16]);
			reg_rd(drab_pkg::REG_DST_HIGH, r[5]);
			check("dst high", {16'h0, r[5]}, {16'h0, ramData[15:0]});
		end
		check("early ready", {31'h0, toolReady}, 32'h0);
		dmaXferDone <= 1'b1;
		@(posedge clk);
		dmaXferDone <= 1'b0;
	endtask : dma_serve

	// dma answers only once software has set it up
	initial forever begin
		@(posedge clk);
		if (dmaOn && addressSetupRequest === 1'b1) dma_serve();
	end

	task automatic ram_cmd(input logic wr, input logic [23:0] a,
		input logic [31:0] d, input logic good);
		expWr = wr;
		expAddr = a;
		expData = d;
		tool.send(wr, 1'b0, a, d, ok);
		check("ready", {31'h0, ok}, {31'h0, good});
	endtask : ram_cmd

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		{dmaSetupDone, dmaXferDone, regRd, regWr, dmaOn} = '0;
		{regAddr, regBe, regWdata} = '0;
		busIn = '0;
		ramData = 32'h1357_2468;
		{mismatches, cmpCount, setupCount, trigCount} = '0;
		do_reset();
		for (i = 0; i < 8; i++) begin
			reg_rd(3'(i), w);
			check("reset reg", {16'h0, w}, 32'h0);
		end
		reg_wr(drab_pkg::REG_BUF_LOW, 2'h3, 16'h1234);
		reg_wr(drab_pkg::REG_BUF_LOW, drab_pkg::BE_LOW, 16'hffab);
		reg_rd(drab_pkg::REG_BUF_LOW, w);
		check("low bytes", {16'h0, w}, 32'h12ab);
		reg_wr(drab_pkg::REG_BUF_HIGH, drab_pkg::BE_HIGH, 16'h5aff);
		reg_rd(drab_pkg::REG_BUF_HIGH, w);
		check("high bytes", {16'h0, w}, 32'h5a00);
		reg_wr(drab_pkg::REG_SRC_LOW, 2'h3, 16'hbeef);
		reg_rd(drab_pkg::REG_SRC_LOW, w);
		check("src locked", {16'h0, w}, 32'h0);
		reg_wr(drab_pkg::REG_DST_HIGH, 2'h3, 16'hbeef);
		reg_rd(drab_pkg::REG_DST_HIGH, w);
		// no RAM command yet, so dst high mirrors the low buffer
		check("dst locked", {16'h0, w}, 32'h12ab);
		// clock enable low: a buffer write must not land
		clkEn <= 1'b0;
		reg_wr(drab_pkg::REG_BUF_LOW, 2'h3, 16'h0f0f);
		clkEn <= 1'b1;
		reg_rd(drab_pkg::REG_BUF_LOW, w);
		check("frozen", {16'h0, w}, 32'h12ab);
		// dma ready: write, then a read of the last RAM word
		dmaOn = 1'b1;
		ram_cmd(1'b1, 24'hffc010, 32'h89ab_cdef, 1'b1);
		ram_cmd(1'b0, 24'hffe7fc, 32'h0, 1'b1);
		check("read data", toolRdData, ramData);
		// just outside the window on both sides: no dma at all
		t = setupCount;
		ram_cmd(1'b1, 24'hffe800, 32'h1, 1'b1);
		ram_cmd(1'b0, 24'hffbffc, 32'h0, 1'b1);
		check("no setup", setupCount - t, 0);
		// RAM trigger: data read fires, fetch and next word do not; ROM trigger: fetch fires, next word does not
		tool.send(1'b0, 1'b1, 24'hffc020, 32'h0, ok);
		bus_hit(32'hffff_c023, 1'b0, 1);
		bus_hit(32'hffff_c020, 1'b1, 0);
		bus_hit(32'hffff_c024, 1'b0, 0);
		tool.send(1'b0, 1'b1, 24'h000104, 32'h1, ok);
		bus_hit(32'h0000_0107, 1'b1, 1);
		bus_hit(32'h0000_0108, 1'b1, 0);
		// init probe: trigger on a word, then write it through the port
		tool.send(1'b0, 1'b1, 24'hffc030, 32'h0, ok);
		t = trigCount;
		ram_cmd(1'b1, 24'hffc030, 32'h0102_0304, 1'b1);
		check("probe trigger", trigCount - t, 1);
		// reset forgets the trigger; without dma init no ready comes
		dmaOn = 1'b0;
		do_reset();
		bus_hit(32'hffff_c030, 1'b0, 0);
		ram_cmd(1'b1, 24'hffc040, 32'h5, 1'b0);
		// request held through reset release locks the port
		tool.hold_req(1'b1);
		do_reset();
		tool.send(1'b0, 1'b1, 24'hffc020, 32'h0, ok);
		check("locked", {31'h0, ok}, 32'h0);
		do_reset();
		tool.send(1'b0, 1'b1, 24'hffc020, 32'h0, ok);
		check("after reset", {31'h0, ok}, 32'h1);
		complete_run();
	end
endmodule : tb_drab_port
